/* File: mie_exec.sv */
// Execution unit for subtract-immediate, table read, timer-0 mode moves and exclusive-OR
`timescale 1ns/1ps
`include "mie_map.svh"

module mie_exec (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Decoder side
    input wire logic insn_valid_in,
    input wire mie_pkg::mie_insn_s insn_in,
    output logic insn_ready_out,
    // Data register file side
    input wire logic [7:0] file_rdata_in,
    output logic file_we_out,
    output logic [5:0] file_addr_out,
    output logic [7:0] file_wdata_out,
    // Program ROM side
    output logic rom_rd_out,
    output logic [10:0] rom_addr_out,
    input wire logic [13:0] rom_data_in,
    // Core state seen by neighbours
    output logic [7:0] work_out,
    output mie_pkg::mie_flags_s flags_out,
    output logic [7:0] timer_zero_mode_out,
    // AXI4-Lite slave
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [7:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out
);
    import mie_pkg::*;

    // ==========================================================
    // Address decode shared by the read and write paths
    typedef enum logic [2:0] {
        SEL_WORK,
        SEL_FLAGS,
        SEL_TPH,
        SEL_TDH,
        SEL_TMODE,
        SEL_STATE,
        SEL_NONE
    } mie_sel_e;

    function automatic mie_sel_e reg_select(input logic [7:0] addr);
        begin
            case (addr)
                `MIE_OFS_WORK: reg_select = SEL_WORK;
                `MIE_OFS_FLAGS: reg_select = SEL_FLAGS;
                `MIE_OFS_TPH: reg_select = SEL_TPH;
                `MIE_OFS_TDH: reg_select = SEL_TDH;
                `MIE_OFS_TMODE: reg_select = SEL_TMODE;
                `MIE_OFS_STATE: reg_select = SEL_STATE;
                default: reg_select = SEL_NONE;
            endcase
        end
    endfunction

    // ==========================================================
    // State declarations
    mie_state_e state_q, state_d;
    logic [7:0] work_q, work_d;
    mie_flags_s flags_q, flags_d;
    logic [2:0] tph_q, tph_d;
    logic [5:0] tdh_q, tdh_d;
    logic [7:0] tmode_q, tmode_d;
    logic [10:0] rom_addr_q, rom_addr_d;
    logic file_we_q, file_we_d;
    logic [5:0] file_addr_q, file_addr_d;
    logic [7:0] file_wdata_q, file_wdata_d;

    logic aw_held_q, aw_held_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic w_held_q, w_held_d;
    logic [7:0] w_data_q, w_data_d;
    logic w_lane0_q, w_lane0_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    logic insn_take;
    logic sw_write;
    mie_sel_e sw_sel;
    logic [7:0] alu_operand;
    logic [7:0] alu_result;
    mie_flags_s alu_flags;

    // ==========================================================
    // Arithmetic unit; the register XOR reads the file slot the decoder addresses
    always_comb begin
        alu_operand = insn_in.constant_byte;
        if (insn_in.op == OP_REGISTER_EXCLUSIVE_OR) begin
            alu_operand = file_rdata_in;
        end
    end

    mie_alu u_alu (
        .op_in(insn_in.op),
        .work_in(work_q),
        .operand_in(alu_operand),
        .result_out(alu_result),
        .flags_out(alu_flags)
    );

    // ==========================================================
    // Bus write is performed once address and data are both held
    assign sw_write = aw_held_q && w_held_q && !bvalid_q;
    assign sw_sel = reg_select(aw_addr_q);
    // Only the idle state accepts a new instruction; the table fetch stalls the decoder
    assign insn_ready_out = (state_q == ST_IDLE);
    assign insn_take = insn_valid_in && insn_ready_out;

    // ==========================================================
    // Core next state: instruction effects win over a bus write in the same cycle,
    // so software never loses a hardware update it raced with
    always_comb begin
        state_d = state_q;
        work_d = work_q;
        flags_d = flags_q;
        tph_d = tph_q;
        tdh_d = tdh_q;
        tmode_d = tmode_q;
        rom_addr_d = rom_addr_q;
        file_we_d = 1'b0;
        file_addr_d = file_addr_q;
        file_wdata_d = file_wdata_q;
        // Software writes, low byte lane only
        if (sw_write && w_lane0_q) begin
            case (sw_sel)
                SEL_WORK: work_d = w_data_q;
                SEL_FLAGS: begin
                    flags_d.result_null_flag = w_data_q[`MIE_FLAG_Z_BIT];
                    flags_d.half_carry_flag = w_data_q[`MIE_FLAG_DC_BIT];
                    flags_d.borrow_out_flag = w_data_q[`MIE_FLAG_C_BIT];
                end
                SEL_TPH: tph_d = w_data_q[2:0];
                SEL_TMODE: tmode_d = w_data_q;
                default: begin
                end
            endcase
        end
        case (state_q)
            ST_IDLE: begin
                if (insn_take) begin
                    case (insn_in.op)
                        OP_IMMEDIATE_MINUS_WORKING: begin
                            work_d = alu_result;
                            flags_d = alu_flags;
                        end
                        OP_PROGRAM_ROM_TABLE_READ: begin
                            rom_addr_d = {tph_q, work_q};
                            state_d = ST_FETCH;
                        end
                        OP_TIMER_ZERO_MODE_LOAD: begin
                            tmode_d = work_q;
                        end
                        OP_TIMER_ZERO_MODE_READBACK: begin
                            work_d = tmode_q;
                        end
                        OP_REGISTER_EXCLUSIVE_OR: begin
                            flags_d.result_null_flag = alu_flags.result_null_flag;
                            if (insn_in.target_select_bit) begin
                                file_we_d = 1'b1;
                                file_addr_d = insn_in.file_slot;
                                file_wdata_d = alu_result;
                            end else begin
                                work_d = alu_result;
                            end
                        end
                        OP_IMMEDIATE_EXCLUSIVE_OR: begin
                            work_d = alu_result;
                            flags_d.result_null_flag = alu_flags.result_null_flag;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_FETCH: begin
                // Second cycle: the ROM word for the held address is sampled here
                work_d = rom_data_in[7:0];
                tdh_d = rom_data_in[13:8];
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Core registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            work_q <= `MIE_RST_WORK;
            flags_q <= '0;
            tph_q <= `MIE_RST_TPH;
            tdh_q <= `MIE_RST_TDH;
            tmode_q <= `MIE_RST_TMODE;
            rom_addr_q <= '0;
            file_we_q <= 1'b0;
            file_addr_q <= '0;
            file_wdata_q <= '0;
        end else begin
            state_q <= state_d;
            work_q <= work_d;
            flags_q <= flags_d;
            tph_q <= tph_d;
            tdh_q <= tdh_d;
            tmode_q <= tmode_d;
            rom_addr_q <= rom_addr_d;
            file_we_q <= file_we_d;
            file_addr_q <= file_addr_d;
            file_wdata_q <= file_wdata_d;
        end
    end

    // ==========================================================
    // AXI4-Lite write channels: address and data may come in either order
    always_comb begin
        aw_held_d = aw_held_q;
        aw_addr_d = aw_addr_q;
        w_held_d = w_held_q;
        w_data_d = w_data_q;
        w_lane0_d = w_lane0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid_in && !aw_held_q) begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !w_held_q) begin
            w_held_d = 1'b1;
            w_data_d = s_axi_wdata_in[7:0];
            w_lane0_d = s_axi_wstrb_in[0];
        end
        if (sw_write) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            // Read-only and unmapped offsets answer with an error and change nothing
            bresp_d = (sw_sel == SEL_NONE || sw_sel == SEL_TDH || sw_sel == SEL_STATE) ?
                      `MIE_RESP_SLVERR : `MIE_RESP_OKAY;
        end
        if (bvalid_q && s_axi_bready_in) begin
            bvalid_d = 1'b0;
        end
    end

    // AXI4-Lite read channel, one outstanding read
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid_in && !rvalid_q) begin
            rvalid_d = 1'b1;
            rdata_d = 32'h0000_0000;
            rresp_d = `MIE_RESP_OKAY;
            case (reg_select(s_axi_araddr_in))
                SEL_WORK: rdata_d[7:0] = work_q;
                SEL_FLAGS: begin
                    rdata_d[`MIE_FLAG_Z_BIT] = flags_q.result_null_flag;
                    rdata_d[`MIE_FLAG_DC_BIT] = flags_q.half_carry_flag;
                    rdata_d[`MIE_FLAG_C_BIT] = flags_q.borrow_out_flag;
                end
                SEL_TPH: rdata_d[2:0] = tph_q;
                SEL_TDH: rdata_d[5:0] = tdh_q;
                SEL_TMODE: rdata_d[7:0] = tmode_q;
                SEL_STATE: rdata_d[0] = (state_q == ST_FETCH);
                default: rresp_d = `MIE_RESP_SLVERR;
            endcase
        end else if (rvalid_q && s_axi_rready_in) begin
            rvalid_d = 1'b0;
        end
    end

    // Bus registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_lane0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `MIE_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `MIE_RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            aw_addr_q <= aw_addr_d;
            w_held_q <= w_held_d;
            w_data_q <= w_data_d;
            w_lane0_q <= w_lane0_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // ==========================================================
    // Output drive
    assign s_axi_awready_out = !aw_held_q;
    assign s_axi_wready_out = !w_held_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;
    assign file_we_out = file_we_q;
    assign file_addr_out = file_addr_q;
    assign file_wdata_out = file_wdata_q;
    assign rom_rd_out = (state_q == ST_FETCH);
    assign rom_addr_out = rom_addr_q;
    assign work_out = work_q;
    assign flags_out = flags_q;
    assign timer_zero_mode_out = tmode_q;

endmodule

/* File: mie_map.svh */
// Offsets, field positions, reset values and timing counts of the instruction subset executor
`ifndef MIE_MAP_SVH
`define MIE_MAP_SVH

// ==========================================================
// Widths
`define MIE_DATA_W 8
`define MIE_FILE_AW 6
`define MIE_ROM_AW 11
`define MIE_ROM_DW 14
`define MIE_TPH_W 3
`define MIE_TDH_W 6
`define MIE_AXI_AW 8

// ==========================================================
// Register byte offsets on the AXI4-Lite bus
`define MIE_OFS_WORK 8'h00
`define MIE_OFS_FLAGS 8'h04
`define MIE_OFS_TPH 8'h08
`define MIE_OFS_TDH 8'h0C
`define MIE_OFS_TMODE 8'h10
`define MIE_OFS_STATE 8'h14

// ==========================================================
// Field positions in the flag register
`define MIE_FLAG_Z_BIT 0
`define MIE_FLAG_DC_BIT 1
`define MIE_FLAG_C_BIT 2

// ==========================================================
// Reset values
`define MIE_RST_WORK 8'h00
`define MIE_RST_TMODE 8'h00
`define MIE_RST_TPH 3'h0
`define MIE_RST_TDH 6'h00

// ==========================================================
// Timing: cycles occupied by each instruction
`define MIE_CYC_TABLE 2
`define MIE_CYC_SINGLE 1

// ==========================================================
// AXI response codes
`define MIE_RESP_OKAY 2'h0
`define MIE_RESP_SLVERR 2'h2

`endif

/* File: mie_pkg.sv */
// Types shared by the instruction subset executor files
package mie_pkg;

    // ==========================================================
    // Instruction selection from the decoder
    typedef enum logic [2:0] {
        OP_NONE,
        OP_IMMEDIATE_MINUS_WORKING,
        OP_PROGRAM_ROM_TABLE_READ,
        OP_TIMER_ZERO_MODE_LOAD,
        OP_TIMER_ZERO_MODE_READBACK,
        OP_REGISTER_EXCLUSIVE_OR,
        OP_IMMEDIATE_EXCLUSIVE_OR
    } mie_op_e;

    // ==========================================================
    // One decoded instruction
    typedef struct packed {
        mie_op_e op;
        logic [7:0] constant_byte;
        logic [5:0] file_slot;
        logic target_select_bit;
    } mie_insn_s;

    // ==========================================================
    // Status flags
    typedef struct packed {
        logic borrow_out_flag;
        logic half_carry_flag;
        logic result_null_flag;
    } mie_flags_s;

    // ==========================================================
    // Executor sequencing states
    typedef enum logic {
        ST_IDLE,
        ST_FETCH
    } mie_state_e;

endpackage

/* File: mie_alu.sv */
// Arithmetic and logic unit of the instruction subset executor
`timescale 1ns/1ps
`include "mie_map.svh"

module mie_alu (
    input wire mie_pkg::mie_op_e op_in,
    input wire logic [7:0] work_in,
    input wire logic [7:0] operand_in,
    output logic [7:0] result_out,
    output mie_pkg::mie_flags_s flags_out
);
    import mie_pkg::*;

    logic [8:0] diff_full;
    logic [4:0] diff_low;

    // Two's complement difference, nine bits so the borrow is visible
    always_comb begin
        diff_full = {1'b0, operand_in} - {1'b0, work_in};
        diff_low = {1'b0, operand_in[3:0]} - {1'b0, work_in[3:0]};
    end

    // Result select and flags; for non-arithmetic ops only the null flag is used upstream
    always_comb begin
        result_out = work_in ^ operand_in;
        flags_out.borrow_out_flag = 1'b0;
        flags_out.half_carry_flag = 1'b0;
        if (op_in == OP_IMMEDIATE_MINUS_WORKING) begin
            result_out = diff_full[7:0];
            flags_out.borrow_out_flag = ~diff_full[8];
            flags_out.half_carry_flag = ~diff_low[4]; // Inverted nibble borrow, like the carry
        end
        flags_out.result_null_flag = (result_out == 8'h00);
    end

endmodule

/* File: mie_exec_chk.sv */
// Concurrent checks on the instruction port of the instruction subset executor
`timescale 1ns/1ps

module mie_exec_chk (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic insn_valid_in,
    input wire mie_pkg::mie_insn_s insn_in,
    input wire logic insn_ready_out,
    input wire logic [7:0] file_rdata_in,
    input wire logic file_we_out,
    input wire logic [5:0] file_addr_out,
    input wire logic [7:0] file_wdata_out,
    input wire logic rom_rd_out,
    input wire logic [10:0] rom_addr_out,
    input wire logic [13:0] rom_data_in,
    input wire logic [7:0] work_out,
    input wire mie_pkg::mie_flags_s flags_out,
    input wire logic [7:0] timer_zero_mode_out
);
    import mie_pkg::*;
    logic tk, xf;
    mie_op_e op;
    // ==========================================================
    // Take strobe; every check below starts from the edge that takes an instruction
    assign tk = insn_valid_in && insn_ready_out;
    assign op = insn_in.op;
    // A taken register XOR aimed at the file slot
    assign xf = tk && op == OP_REGISTER_EXCLUSIVE_OR && insn_in.target_select_bit;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    // ==========================================================
    // Arithmetic, moves, table read and exclusive-OR
    sub_result_a: assert property (
        tk && op == OP_IMMEDIATE_MINUS_WORKING |=> work_out == $past(insn_in.constant_byte) - $past(work_out))
        else $error("subtract result wrong");
    sub_borrow_a: assert property (
        tk && op == OP_IMMEDIATE_MINUS_WORKING |=>
        flags_out.borrow_out_flag == ($past(insn_in.constant_byte) >= $past(work_out)) &&
        flags_out.half_carry_flag == ($past(insn_in.constant_byte[3:0]) >= $past(work_out[3:0])))
        else $error("subtract borrow flags wrong");
    sub_null_a: assert property (
        tk && op == OP_IMMEDIATE_MINUS_WORKING |=> flags_out.result_null_flag == (work_out == 8'h00))
        else $error("subtract null flag wrong");
    table_read_a: assert property (
        tk && op == OP_PROGRAM_ROM_TABLE_READ |=> rom_rd_out && !insn_ready_out &&
        rom_addr_out[7:0] == $past(work_out) ##1 insn_ready_out && work_out == $past(rom_data_in[7:0]))
        else $error("table read address or data wrong");
    mode_load_a: assert property (
        tk && op == OP_TIMER_ZERO_MODE_LOAD |=> timer_zero_mode_out == $past(work_out) && $stable(work_out))
        else $error("mode load wrong");
    mode_read_a: assert property (
        tk && op == OP_TIMER_ZERO_MODE_READBACK |=> work_out == $past(timer_zero_mode_out) &&
        $stable(timer_zero_mode_out))
        else $error("mode readback wrong");
    xor_file_a: assert property (
        xf |=> file_we_out &&
        file_addr_out == $past(insn_in.file_slot) && file_wdata_out == ($past(work_out) ^ $past(file_rdata_in)) &&
        flags_out.result_null_flag == (file_wdata_out == 8'h00) ##1 (!file_we_out || $past(xf)))
        else $error("xor to file slot wrong");
    xor_work_a: assert property (
        tk && op == OP_REGISTER_EXCLUSIVE_OR && !insn_in.target_select_bit |=> !file_we_out &&
        work_out == ($past(work_out) ^ $past(file_rdata_in)) && flags_out.result_null_flag == (work_out == 8'h00))
        else $error("xor to working register wrong");
    xor_imm_a: assert property (
        tk && op == OP_IMMEDIATE_EXCLUSIVE_OR |=> work_out == ($past(work_out) ^ $past(insn_in.constant_byte)) &&
        flags_out.result_null_flag == (work_out == 8'h00))
        else $error("immediate xor wrong");
    single_cycle_a: assert property (
        tk && op != OP_PROGRAM_ROM_TABLE_READ |=> insn_ready_out)
        else $error("single cycle instruction stalled");
endmodule

bind mie_exec mie_exec_chk u_mie_exec_chk (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .insn_valid_in(insn_valid_in), .insn_in(insn_in),
    .insn_ready_out(insn_ready_out), .file_rdata_in(file_rdata_in), .file_we_out(file_we_out),
    .file_addr_out(file_addr_out), .file_wdata_out(file_wdata_out), .rom_rd_out(rom_rd_out),
    .rom_addr_out(rom_addr_out), .rom_data_in(rom_data_in), .work_out(work_out), .flags_out(flags_out),
    .timer_zero_mode_out(timer_zero_mode_out));

/* File: mie_exec_tb.sv */
// Self-checking testbench of the instruction subset executor
`timescale 1ns/1ps
`include "mie_map.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end

module testbench;
    import mie_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic iv = 1'b0;
    mie_insn_s insn = '0;
    logic [7:0] frd = 8'h00;
    logic [13:0] romd = 14'h0000;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h00000000;
    logic [3:0] ws = 4'hF;
    logic rdy, fwe, romrd, awr, wrd, bv, arr, rv;
    logic [5:0] fad;
    logic [7:0] fwd, wk, tm, r8;
    logic [10:0] roma;
    mie_flags_s fl;
    logic [1:0] br, rr;
    logic [31:0] rd;
    logic [2:0] fx;
    int errors = 0;
    int cmp_count = 0;
    int i;
    // Subtract cases: wrap negative, plain positive, equal operands giving zero
    logic [7:0] sw [3] = '{8'h06, 8'h05, 8'h37};
    logic [7:0] si [3] = '{8'h05, 8'h06, 8'h37};

    // ==========================================================
    // Clock and device
    always #25 sys_clk_in = ~sys_clk_in;

    mie_exec u_mie_exec (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .insn_valid_in(iv), .insn_in(insn), .insn_ready_out(rdy),
        .file_rdata_in(frd), .file_we_out(fwe), .file_addr_out(fad), .file_wdata_out(fwd),
        .rom_rd_out(romrd), .rom_addr_out(roma), .rom_data_in(romd), .work_out(wk), .flags_out(fl),
        .timer_zero_mode_out(tm), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(br), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
        .s_axi_rdata_out(rd), .s_axi_rresp_out(rr));

    // ==========================================================
    // Verdict; the only place the run ends
    task automatic wrap_up();
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // AXI4-Lite write; handshakes are sampled 1 ns after the preceding edge, 49 ns before the edge that takes them
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
        logic pa, pw, pb, ta, tw, tb;
        logic [1:0] rsp;
        int n;
        @(posedge sys_clk_in);
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        awa <= a;
        wd <= d;
        ws <= s;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        for (n = 0; n < 20 && pb; n++) begin
            #1;
            ta = pa && awr;
            tw = pw && wrd;
            tb = bv;
            rsp = br;
            @(posedge sys_clk_in);
            if (ta) begin
                awv <= 1'b0;
                pa = 1'b0;
            end
            if (tw) begin
                wv <= 1'b0;
                pw = 1'b0;
            end
            if (tb) begin
                bre <= 1'b0;
                pb = 1'b0;
            end
        end
        if (pb) begin
            errors++;
            wrap_up();
        end
        `CHK("bresp", e, rsp)
    endtask

    // AXI4-Lite read with expected data and response
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic pa, pb, ta, tb;
        logic [1:0] rsp;
        logic [31:0] dat;
        int n;
        @(posedge sys_clk_in);
        arv <= 1'b1;
        rre <= 1'b1;
        ara <= a;
        pa = 1'b1;
        pb = 1'b1;
        for (n = 0; n < 20 && pb; n++) begin
            #1;
            ta = pa && arr;
            tb = rv;
            rsp = rr;
            dat = rd;
            @(posedge sys_clk_in);
            if (ta) begin
                arv <= 1'b0;
                pa = 1'b0;
            end
            if (tb) begin
                rre <= 1'b0;
                pb = 1'b0;
            end
        end
        if (pb) begin
            errors++;
            wrap_up();
        end
        `CHK("rresp", er, rsp)
        `CHK("rdata", e, dat)
    endtask

    // Offer one instruction; returns 1 ns after the edge that took it, when single-cycle effects have landed
    task automatic exec(input mie_op_e op, input logic [7:0] c, input logic [5:0] s, input logic t);
        logic ok;
        int n;
        @(posedge sys_clk_in);
        iv <= 1'b1;
        insn <= '{op: op, constant_byte: c, file_slot: s, target_select_bit: t};
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++) begin
            #1;
            ok = (rdy === 1'b1);
            @(posedge sys_clk_in);
        end
        iv <= 1'b0;
        if (!ok) begin
            errors++;
            wrap_up();
        end
        #1;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        // Reset values of every mapped word, then refused and masked accesses
        for (i = 0; i < 6; i++) axi_rd(8'(i * 4), 32'h00000000, `MIE_RESP_OKAY);
        axi_rd(8'h40, 32'h00000000, `MIE_RESP_SLVERR);
        axi_wr(`MIE_OFS_TDH, 32'h0000003F, 4'hF, `MIE_RESP_SLVERR);
        axi_rd(`MIE_OFS_TDH, 32'h00000000, `MIE_RESP_OKAY);
        axi_wr(`MIE_OFS_WORK, 32'h000000AA, 4'h0, `MIE_RESP_OKAY);
        `CHK("work_masked", 8'h00, wk)
        // Subtract: borrow, no borrow, zero result
        for (i = 0; i < 3; i++) begin
            axi_wr(`MIE_OFS_WORK, {24'h000000, sw[i]}, 4'hF, `MIE_RESP_OKAY);
            exec(OP_IMMEDIATE_MINUS_WORKING, si[i], 6'h00, 1'b0);
            r8 = si[i] - sw[i];
            fx = {si[i] >= sw[i], si[i][3:0] >= sw[i][3:0], r8 == 8'h00};
            `CHK("sub_work", r8, wk)
            `CHK("sub_flags", fx, fl)
            axi_rd(`MIE_OFS_FLAGS, {29'h0000000, fx}, `MIE_RESP_OKAY);
        end
        // Table read across the two cycles; the ROM word is scrambled once sampled
        axi_wr(`MIE_OFS_TPH, 32'h00000002, 4'hF, `MIE_RESP_OKAY);
        axi_wr(`MIE_OFS_WORK, 32'h00000034, 4'hF, `MIE_RESP_OKAY);
        romd <= 14'h35AA;
        exec(OP_PROGRAM_ROM_TABLE_READ, 8'h00, 6'h00, 1'b0);
        `CHK("rom_rd", 1'b1, romrd)
        `CHK("rom_addr", 11'h234, roma)
        `CHK("ready_fetch", 1'b0, rdy)
        @(posedge sys_clk_in);
        romd <= 14'h0A55;
        #1;
        `CHK("tbl_work", 8'hAA, wk)
        `CHK("ready_after", 1'b1, rdy)
        axi_rd(`MIE_OFS_TDH, 32'h00000035, `MIE_RESP_OKAY);
        // Immediate xor, non-zero then zero
        exec(OP_IMMEDIATE_EXCLUSIVE_OR, 8'hA5, 6'h00, 1'b0);
        `CHK("xori_work", 8'h0F, wk)
        `CHK("xori_z", 1'b0, fl.result_null_flag)
        exec(OP_IMMEDIATE_EXCLUSIVE_OR, 8'h0F, 6'h00, 1'b0);
        `CHK("xori_z", 1'b1, fl.result_null_flag)
        // Mode load and readback
        axi_wr(`MIE_OFS_WORK, 32'h000000AA, 4'hF, `MIE_RESP_OKAY);
        exec(OP_TIMER_ZERO_MODE_LOAD, 8'h00, 6'h00, 1'b0);
        `CHK("mode_load", 8'hAA, tm)
        axi_wr(`MIE_OFS_WORK, 32'h00000012, 4'hF, `MIE_RESP_OKAY);
        exec(OP_TIMER_ZERO_MODE_READBACK, 8'h00, 6'h00, 1'b0);
        `CHK("mode_read", 8'hAA, wk)
        `CHK("mode_kept", 8'hAA, tm)
        // Register xor to the top slot, then to the working register with a zero result
        axi_wr(`MIE_OFS_WORK, 32'h000000F0, 4'hF, `MIE_RESP_OKAY);
        frd <= 8'hA5;
        exec(OP_REGISTER_EXCLUSIVE_OR, 8'h00, 6'h3F, 1'b1);
        `CHK("file_we", 1'b1, fwe)
        `CHK("file_addr", 6'h3F, fad)
        `CHK("file_data", 8'h55, fwd)
        `CHK("xor_work_kept", 8'hF0, wk)
        `CHK("xor_file_z", 1'b0, fl.result_null_flag)
        frd <= 8'hF0;
        exec(OP_REGISTER_EXCLUSIVE_OR, 8'h00, 6'h05, 1'b0);
        `CHK("file_we_idle", 1'b0, fwe)
        `CHK("xor_work", 8'h00, wk)
        `CHK("xor_z", 1'b1, fl.result_null_flag)
        // Empty slot changes nothing; then a reset in mid-run clears the mode register
        exec(OP_NONE, 8'hFF, 6'h00, 1'b0);
        `CHK("none_work", 8'h00, wk)
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        #1;
        `CHK("mode_rst", 8'h00, tm)
        // Software writes of the flag word and the mode register
        axi_wr(`MIE_OFS_FLAGS, 32'h00000005, 4'hF, `MIE_RESP_OKAY);
        `CHK("flags_sw", 3'h5, fl)
        axi_wr(`MIE_OFS_TMODE, 32'h0000005A, 4'hF, `MIE_RESP_OKAY);
        axi_rd(`MIE_OFS_TMODE, 32'h0000005A, `MIE_RESP_OKAY);
        wrap_up();
    end
endmodule
